// ===== include/dutc_pkg.sv
// package for the converter update and trigger control block
// Function
// - enable converts held code per control
// - auto trigger enable selects hardware trigger
// - rising trigger edge loads held code
// - still-high trigger starts no new conversion
// - edges during conversion are dropped
// - trigger follows raw event flag, not interrupts
// - ten-bit code, output scales over 1023
// - result feeds comparators, optionally output pad
// - reference selection shared with the ADC
// - reference is supply, internal or pin
// - three-bit source select encoding as listed
// - shadow code loads only via high byte write (manual) or trigger edge (auto)
// - manual mode high write loads shadow now
// - justify applies at next load: high write (manual) or trigger edge (auto)
package dutc_pkg;
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_CODE_LOW = 4'h1;
    localparam logic [3:0] ADDR_CODE_HIGH = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_REFSEL = 4'h4;
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_PAD_OE_BIT = 1;
    localparam int CTL_LEFT_BIT = 2;
    localparam int CTL_TSEL_LSB = 4;
    localparam int CTL_AUTO_BIT = 7;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_MASK = 8'hF7;
    localparam logic [9:0] CODE_RESET = 10'h000;
    localparam logic [1:0] REFSEL_RESET = 2'h0;
    localparam int CODE_W = 10;
    localparam int CONV_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] CONV_CYCLES_W = CONV_CYCLES[7:0];
    typedef enum logic [2:0] {
        TSRC_CMP0, TSRC_CMP1, TSRC_EXT0, TSRC_T0_CMP,
        TSRC_T0_OVF, TSRC_T1_CMPB, TSRC_T1_OVF, TSRC_T1_CAPT
    } dutc_tsrc_e;
    typedef enum logic [1:0] {
        REF_ANALOG_SUPPLY, REF_INTERNAL_2V56, REF_PIN, REF_RESERVED
    } dutc_ref_e;
    typedef struct packed {
        logic auto_trigger_enable;
        dutc_tsrc_e trigger_source_select;
        logic spare_bit;
        logic left_justify;
        logic pad_output_enable;
        logic converter_enable;
    } dutc_ctrl_s;
    typedef struct packed {
        logic [9:0] code;
        logic converter_enable;
        logic pad_output_enable;
        logic conv_start;
        logic busy;
        dutc_ref_e ref_sel;
    } dutc_analog_s;
endpackage

// ===== logic/dutc_top.sv
// converter control: register slave, trigger detector, shadow code and conversion timer
module dutc_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] event_flags,
    output dutc_pkg::dutc_analog_s analog_ctrl
);
    logic rst_meta_ff, rst_sync_ff;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    wire logic rst_n = rst_sync_ff;

    // event flags may come from other logic or pins; synchronise them all
    logic [7:0] flag_meta_ff, flag_sync_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_meta_ff <= 8'h00;
            flag_sync_ff <= 8'h00;
        end else begin
            flag_meta_ff <= event_flags;
            flag_sync_ff <= flag_meta_ff;
        end
    end

    dutc_pkg::dutc_ctrl_s ctrl_ff, nxt_ctrl;
    logic [7:0] low_ff, nxt_low;
    logic [7:0] high_ff, nxt_high;
    logic [1:0] ref_ff, nxt_ref;
    logic [9:0] shadow_ff, nxt_shadow;
    logic prev_trig_ff, nxt_prev_trig;
    logic [7:0] conv_cnt_ff, nxt_conv_cnt;
    logic start_ff, nxt_start;
    logic ack_ff, nxt_ack;
    logic [31:0] rdata_ff, nxt_rdata;
    logic dropped_ff, nxt_dropped;

    // justify only takes effect when the code is assembled at load time
    function automatic logic [9:0] assemble(input logic left, input logic [7:0] hi, input logic [7:0] lo);
        assemble = left ? {hi, lo[7:6]} : {hi[1:0], lo};
    endfunction

    wire logic access = (avs_read | avs_write) & ~ack_ff;
    wire logic wr = avs_write & ~ack_ff;
    wire logic high_wr = wr && avs_address == dutc_pkg::ADDR_CODE_HIGH && avs_byteenable[0];
    wire logic cur_trig = flag_sync_ff[ctrl_ff.trigger_source_select];
    wire logic trig_edge = cur_trig & ~prev_trig_ff;
    wire logic busy = conv_cnt_ff != 8'h00;

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_low = low_ff;
        nxt_high = high_ff;
        nxt_ref = ref_ff;
        nxt_shadow = shadow_ff;
        nxt_prev_trig = cur_trig;
        nxt_conv_cnt = busy ? conv_cnt_ff - 8'h01 : 8'h00;
        nxt_start = 1'b0;
        nxt_ack = access;
        nxt_rdata = 32'h0000_0000;
        nxt_dropped = dropped_ff;
        if (wr && avs_byteenable[0]) begin
            unique case (avs_address)
                dutc_pkg::ADDR_CONTROL:
                    nxt_ctrl = dutc_pkg::dutc_ctrl_s'(avs_writedata[7:0] & dutc_pkg::CONTROL_MASK);
                dutc_pkg::ADDR_CODE_LOW: nxt_low = avs_writedata[7:0];
                dutc_pkg::ADDR_CODE_HIGH: nxt_high = avs_writedata[7:0];
                dutc_pkg::ADDR_STATUS: nxt_dropped = dropped_ff & ~avs_writedata[1];
                dutc_pkg::ADDR_REFSEL: nxt_ref = avs_writedata[1:0];
                default: ;
            endcase
        end
        if (ctrl_ff.converter_enable) begin
            if (!ctrl_ff.auto_trigger_enable) begin
                if (high_wr) begin
                    nxt_shadow = assemble(ctrl_ff.left_justify, avs_writedata[7:0], low_ff);
                    nxt_start = 1'b1;
                    nxt_conv_cnt = dutc_pkg::CONV_CYCLES_W;
                end
            end else if (trig_edge) begin
                if (!busy) begin
                    nxt_shadow = assemble(ctrl_ff.left_justify, high_ff, low_ff);
                    nxt_start = 1'b1;
                    nxt_conv_cnt = dutc_pkg::CONV_CYCLES_W;
                end else begin
                    nxt_dropped = 1'b1;
                end
            end
        end
        if (access && avs_read) begin
            unique case (avs_address)
                dutc_pkg::ADDR_CONTROL: nxt_rdata = {24'h000000, ctrl_ff};
                dutc_pkg::ADDR_CODE_LOW: nxt_rdata = {24'h000000, low_ff};
                dutc_pkg::ADDR_CODE_HIGH: nxt_rdata = {24'h000000, high_ff};
                dutc_pkg::ADDR_STATUS: nxt_rdata = {20'h00000, shadow_ff, dropped_ff, busy};
                dutc_pkg::ADDR_REFSEL: nxt_rdata = {30'h00000000, ref_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= dutc_pkg::dutc_ctrl_s'(dutc_pkg::CONTROL_RESET);
            low_ff <= 8'h00;
            high_ff <= 8'h00;
            ref_ff <= dutc_pkg::REFSEL_RESET;
            shadow_ff <= dutc_pkg::CODE_RESET;
            prev_trig_ff <= 1'b0;
            conv_cnt_ff <= 8'h00;
            start_ff <= 1'b0;
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            dropped_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            low_ff <= nxt_low;
            high_ff <= nxt_high;
            ref_ff <= nxt_ref;
            shadow_ff <= nxt_shadow;
            prev_trig_ff <= nxt_prev_trig;
            conv_cnt_ff <= nxt_conv_cnt;
            start_ff <= nxt_start;
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
            dropped_ff <= nxt_dropped;
        end
    end

    // one wait state: request held until the registered answer is ready
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign avs_readdata = rdata_ff;

    always_comb begin
        analog_ctrl.code = shadow_ff;
        analog_ctrl.converter_enable = ctrl_ff.converter_enable;
        analog_ctrl.pad_output_enable = ctrl_ff.pad_output_enable;
        analog_ctrl.conv_start = start_ff;
        analog_ctrl.busy = busy;
        analog_ctrl.ref_sel = dutc_pkg::dutc_ref_e'(ref_ff);
    end
endmodule

// ===== dv/dutc_evt_model.sv
// event flag source model: sticky flags raised by events, cleared by software
module dutc_evt_model (
    input wire logic clk,
    input wire logic [7:0] set_mask,
    input wire logic [7:0] clr_mask,
    output logic [7:0] event_flags
);
    timeunit 1ns;
    timeprecision 1ps;
    initial event_flags = 8'h00;
    // a flag left uncleared stays high and cannot rise again
    always @(posedge clk) event_flags <= (event_flags | set_mask) & ~clr_mask;
endmodule

// ===== dv/dutc_chk.sv
// port assertions for the converter control block
module dutc_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire dutc_pkg::dutc_analog_s analog_ctrl
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic req = avs_read || avs_write;
    wait_first_a: assert property (req && !$past(req) |-> avs_waitrequest) else $error("no wait state");
    answer_next_a: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("late answer");
    unmapped_zero_a: assert property (avs_read && avs_waitrequest && avs_address > 4'h4 |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    start_enable_a: assert property (analog_ctrl.conv_start |-> analog_ctrl.converter_enable)
        else $error("start while disabled");
    start_pulse_a: assert property (analog_ctrl.conv_start |=> !analog_ctrl.conv_start)
        else $error("start not a pulse");
    no_retrigger_a: assert property (analog_ctrl.busy && $past(analog_ctrl.busy) |-> !analog_ctrl.conv_start)
        else $error("start during conversion");
    busy_len_a: assert property ($rose(analog_ctrl.busy) |-> ##199 analog_ctrl.busy ##1 !analog_ctrl.busy)
        else $error("conversion length wrong");
    code_hold_a: assert property (!analog_ctrl.conv_start |-> $stable(analog_ctrl.code))
        else $error("code changed without load");
endmodule
bind dutc_top dutc_chk dutc_chk_i (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .analog_ctrl(analog_ctrl));

// ===== dv/dutc_top_tb_top.sv
// self-checking testbench for the converter control block
module dutc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [7:0] set_mask = 8'h00, clr_mask = 8'h00, event_flags;
    dutc_pkg::dutc_analog_s analog_ctrl;
    int n_fail = 0, n_checks = 0;
    always #2.5 clk = ~clk;
    dutc_top dutc_top_i (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .event_flags(event_flags), .analog_ctrl(analog_ctrl));
    dutc_evt_model dutc_evt_model_i (.clk(clk), .set_mask(set_mask), .clr_mask(clr_mask), .event_flags(event_flags));
    task automatic tally_and_finish();
        if (n_fail == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    // request held until waitrequest is seen low at a rising edge; read data is taken at that same edge
    task automatic bus(logic wr, logic [3:0] a, logic [7:0] d);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        if (avs_waitrequest !== 1'b0) n_fail++;
        if (avs_waitrequest !== 1'b0) tally_and_finish();
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wait_busy(logic v);
        int i;
        for (i = 0; i < 400 && analog_ctrl.busy !== v; i++) @(negedge clk);
        if (i == 400) n_fail++;
        if (i == 400) tally_and_finish();
    endtask
    task automatic pulse(logic [7:0] s, logic [7:0] c);
        @(posedge clk);
        set_mask <= s;
        clr_mask <= c;
        @(posedge clk);
        set_mask <= 8'h00;
        clr_mask <= 8'h00;
    endtask
    task automatic sc_basic();
        bus(1'b0, dutc_pkg::ADDR_CONTROL, 8'h00);
        chk("control", rd, 32'h0);
        chk("shadow", analog_ctrl.code, 10'h000);
        bus(1'b0, 4'hF, 8'h00);
        chk("unmapped", rd, 32'h0);
        bus(1'b1, dutc_pkg::ADDR_CODE_HIGH, 8'h03);
        chk("disabled", analog_ctrl.code, 10'h000);
        chk("disabled busy", analog_ctrl.busy, 1'b0);
        bus(1'b1, dutc_pkg::ADDR_CONTROL, 8'h01);
        chk("enable out", analog_ctrl.converter_enable, 1'b1);
        bus(1'b1, dutc_pkg::ADDR_CODE_LOW, 8'hA5);
        chk("low only", analog_ctrl.code, 10'h000);
        bus(1'b1, dutc_pkg::ADDR_CODE_HIGH, 8'h02);
        chk("manual", analog_ctrl.code, 10'h2A5);
        chk("busy", analog_ctrl.busy, 1'b1);
        wait_busy(1'b0);
        bus(1'b1, dutc_pkg::ADDR_CONTROL, 8'h0F);
        bus(1'b0, dutc_pkg::ADDR_CONTROL, 8'h00);
        chk("control rd", rd, 32'h07);
        chk("pad", analog_ctrl.pad_output_enable, 1'b1);
        chk("justify wait", analog_ctrl.code, 10'h2A5);
        bus(1'b1, dutc_pkg::ADDR_CODE_HIGH, 8'hFF);
        chk("left", analog_ctrl.code, 10'h3FE);
        wait_busy(1'b0);
    endtask
    task automatic sc_auto();
        logic [9:0] exp;
        exp = 10'h3FE;
        for (int s = 0; s < 8; s++) begin
            bus(1'b1, dutc_pkg::ADDR_CONTROL, {1'b1, s[2:0], 4'h5});
            bus(1'b1, dutc_pkg::ADDR_CODE_HIGH, 8'h10 + s[7:0]);
            chk("auto no load", analog_ctrl.code, exp);
            chk("pad off", analog_ctrl.pad_output_enable, 1'b0);
            pulse(8'h01 << s, 8'h00);
            wait_busy(1'b1);
            exp = {8'h10 + s[7:0], 2'b10};
            chk("auto load", analog_ctrl.code, exp);
            if (s == 0) pulse(8'h00, 8'h01);
            if (s == 0) pulse(8'h01, 8'h00);
            wait_busy(1'b0);
            repeat (8) @(posedge clk);
            chk("no restart", analog_ctrl.busy, 1'b0);
            bus(1'b0, dutc_pkg::ADDR_STATUS, 8'h00);
            chk("dropped", rd[1], s == 0);
            bus(1'b1, dutc_pkg::ADDR_STATUS, 8'h02);
            pulse(8'h00, 8'h01 << s);
        end
        for (int r = 0; r < 3; r++) begin
            bus(1'b1, dutc_pkg::ADDR_REFSEL, r[7:0]);
            bus(1'b0, dutc_pkg::ADDR_REFSEL, 8'h00);
            chk("refsel", rd, r);
            chk("ref out", analog_ctrl.ref_sel, r);
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        sc_basic();
        sc_auto();
        tally_and_finish();
    end
endmodule
